/* File: adq_calc.sv */
// Purpose: Difference and quadrature calculator behind a dual converter serial readout
// Assumes: sclk and frame_select_n are asynchronous and much slower than clk
// Notes:   Registers over AXI4-Lite; both data lines share one enable
`timescale 1ns/1ps
`default_nettype none

module adq_calc
  import adq_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // AXI4-Lite write channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Converter results
  input  wire logic [CODE_W-1:0] conv_code_a,
  input  wire logic [CODE_W-1:0] conv_code_b,
  // Serial link
  input  wire logic              sclk,
  input  wire logic              frame_select_n,
  output logic                   dout_a,
  output logic                   dout_a_oe,
  output logic                   dout_b,
  output logic                   dout_b_oe
);

  adq_ctrl_t         ctrl_reg;
  adq_state_t        state_reg;
  adq_quad_t         quad;
  logic [4:0]        pos_reg;
  logic [31:0]       frame_a_reg;
  logic [31:0]       frame_b_reg;
  logic              oe_reg;
  logic [CODE_W-1:0] code_a_reg;
  logic [CODE_W-1:0] code_b_reg;
  logic [CALC_W-1:0] diff_reg;
  logic              frame_quad_reg;
  logic              frame_calc_reg;

  // Link synchronisers and edge history
  logic sclk_s1_reg;
  logic sclk_s2_reg;
  logic sclk_d_reg;
  logic fsn_s1_reg;
  logic fsn_s2_reg;
  logic fsn_d_reg;
  logic sclk_fall;
  logic fs_fall;
  logic fs_rise;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_d_reg  <= 1'b0;
      fsn_s1_reg  <= 1'b1;
      fsn_s2_reg  <= 1'b1;
      fsn_d_reg   <= 1'b1;
    end else begin
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg  <= sclk_s2_reg;
      fsn_s1_reg  <= frame_select_n;
      fsn_s2_reg  <= fsn_s1_reg;
      fsn_d_reg   <= fsn_s2_reg;
    end
  end

  assign sclk_fall = sclk_d_reg & ~sclk_s2_reg;
  assign fs_fall   = fsn_d_reg & ~fsn_s2_reg;
  assign fs_rise   = ~fsn_d_reg & fsn_s2_reg;

  // Mode decode
  logic quad_mode;
  logic quad_step;

  assign quad_mode = ~ctrl_reg.input_type_select && (ctrl_reg.channel_select == QUAD_CHANNEL);
  assign quad_step = fs_fall && (state_reg == ST_IDLE) && quad_mode;

  // Sampling at the start of a frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      code_a_reg     <= 12'h000;
      code_b_reg     <= 12'h000;
      diff_reg       <= 13'h0000;
      frame_quad_reg <= 1'b0;
      frame_calc_reg <= 1'b0;
    end else if (fs_fall && state_reg == ST_IDLE) begin
      code_a_reg     <= conv_code_a;
      code_b_reg     <= conv_code_b;
      // Fixed one-count low bias kept on purpose: the host corrects it
      diff_reg       <= CALC_W'({1'b0, conv_code_a} - {1'b0, conv_code_b} - DIFF_OFFSET);
      frame_quad_reg <= quad_mode;
      frame_calc_reg <= ctrl_reg.calc_enable;
    end
  end

  adq_quad_track u_quad (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .step     (quad_step),
    .phase_in ({conv_code_a[CODE_W-1], conv_code_b[CODE_W-1]}),
    .quad_out (quad)
  );

  // Frame words, MSB shifted out first
  logic [CALC_W-1:0] calc_word;
  logic [15:0]       second_b;
  logic [31:0]       word_a;
  logic [31:0]       word_b;

  assign calc_word = frame_quad_reg ? CALC_W'(quad) : diff_reg;
  assign second_b  = frame_calc_reg ? {2'b00, calc_word, 1'b0} : {LEAD_ZEROS, code_a_reg, 1'b0};
  assign word_a    = {LEAD_ZEROS, code_a_reg, 1'b0, LEAD_ZEROS, code_b_reg, 1'b0};
  assign word_b    = {LEAD_ZEROS, code_b_reg, 1'b0, second_b};

  // Frame sequencer; a clock fall in the same cycle as the select fall is ignored
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg   <= ST_IDLE;
      pos_reg     <= 5'h00;
      frame_a_reg <= 32'h0000_0000;
      frame_b_reg <= 32'h0000_0000;
      oe_reg      <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (fs_fall) begin
            state_reg   <= ST_LOAD;
            pos_reg     <= 5'h00;
            frame_a_reg <= 32'h0000_0000;
            frame_b_reg <= 32'h0000_0000;
            oe_reg      <= 1'b1;
          end
        end
        ST_LOAD: begin
          if (fs_rise) begin
            state_reg <= ST_IDLE;
            oe_reg    <= 1'b0;
          end else if (sclk_fall) begin
            state_reg   <= ST_ACTIVE;
            pos_reg     <= 5'h01;
            frame_a_reg <= {word_a[30:0], 1'b0};
            frame_b_reg <= {word_b[30:0], 1'b0};
          end else begin
            state_reg   <= ST_ACTIVE;
            frame_a_reg <= word_a;
            frame_b_reg <= word_b;
          end
        end
        ST_ACTIVE: begin
          if (fs_rise || (sclk_fall && pos_reg == LAST_POS)) begin
            state_reg   <= ST_IDLE;
            pos_reg     <= 5'h00;
            frame_a_reg <= 32'h0000_0000;
            frame_b_reg <= 32'h0000_0000;
            oe_reg      <= 1'b0;
          end else if (sclk_fall) begin
            pos_reg     <= 5'(pos_reg + 5'h01);
            frame_a_reg <= {frame_a_reg[30:0], 1'b0};
            frame_b_reg <= {frame_b_reg[30:0], 1'b0};
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          oe_reg    <= 1'b0;
        end
      endcase
    end
  end

  assign dout_a    = frame_a_reg[31];
  assign dout_b    = frame_b_reg[31];
  assign dout_a_oe = oe_reg;
  assign dout_b_oe = oe_reg;

  // AXI4-Lite write path: address and data accepted in either order
  logic              aw_got_reg;
  logic              w_got_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              aw_take;
  logic              w_take;
  logic              do_write;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_mapped;

  assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
  assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;
  assign do_write      = (aw_got_reg | aw_take) & (w_got_reg | w_take);
  assign wr_addr       = aw_got_reg ? awaddr_reg : s_axi_awaddr;
  assign wr_data       = w_got_reg ? wdata_reg : s_axi_wdata;
  assign wr_strb       = w_got_reg ? wstrb_reg : s_axi_wstrb;
  assign wr_mapped     = (wr_addr == OFF_CTRL) || (wr_addr == OFF_STATUS) || (wr_addr == OFF_DIFF)
                         || (wr_addr == OFF_QUAD) || (wr_addr == OFF_CODES);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      aw_got_reg <= 1'b0;
      w_got_reg  <= 1'b0;
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (aw_take) begin
        aw_got_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Only the control word is writable; writes to read-only words are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg <= CTRL_RST;
    end else if (do_write && wr_addr == OFF_CTRL && wr_strb[0]) begin
      ctrl_reg <= wr_data[CTRL_W-1:0];
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // AXI4-Lite read path
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_mux;
  logic        rd_mapped;
  logic        diff_valid;

  // Fully differential codes are not straight binary, so the difference is flagged
  assign diff_valid    = ctrl_reg.straight_binary;
  assign s_axi_arready = ~rvalid_reg;

  always_comb begin
    rd_mux    = 32'h0000_0000;
    rd_mapped = 1'b1;
    case (s_axi_araddr)
      OFF_CTRL:   rd_mux = {26'h0, ctrl_reg};
      OFF_STATUS: rd_mux = {29'h0, (state_reg != ST_IDLE), diff_valid, quad_mode};
      OFF_DIFF:   rd_mux = {19'h0, diff_reg};
      OFF_QUAD:   rd_mux = {19'h0, quad};
      OFF_CODES:  rd_mux = {4'h0, code_b_reg, 4'h0, code_a_reg};
      default:    rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  AST_OE_ON_FRAME: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == ST_IDLE && fs_fall |=> oe_reg && state_reg == ST_LOAD)
    else $error("data lines not enabled after frame select fall");

  AST_RELEASE_RISE: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg != ST_IDLE && fs_rise |=> !oe_reg)
    else $error("data lines not released on frame select rise");

  AST_RELEASE_LAST: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == ST_ACTIVE && sclk_fall && pos_reg == LAST_POS |=> !oe_reg && state_reg == ST_IDLE)
    else $error("data lines not released at the last clock fall");

  AST_LEAD_ZEROS: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(oe_reg) |-> !dout_a && !dout_b ##1 (!dout_a && !dout_b))
    else $error("leading zero missing");

  AST_DIFF_CALC: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == ST_IDLE && fs_fall |=> diff_reg == CALC_W'({1'b0, $past(conv_code_a)} - {1'b0, $past(conv_code_b)} - 13'h0001))
    else $error("difference not A minus B minus one");

  AST_SIGN_SLOT: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == ST_LOAD && !fs_rise && !sclk_fall && frame_calc_reg && !frame_quad_reg
    |=> frame_b_reg[13] == diff_reg[CALC_W-1] && frame_b_reg[12:1] == diff_reg[CODE_W-1:0])
    else $error("difference sign or value misplaced in frame");

  AST_QUAD_GATE: assert property (@(posedge clk) disable iff (sys_rst)
    state_reg == ST_IDLE && fs_fall && !(!ctrl_reg.input_type_select && ctrl_reg.channel_select == 3'h6)
    |=> $stable(quad))
    else $error("quadrature stepped outside its channel setting");

  AST_BVALID_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before acceptance");

endmodule

`default_nettype wire

/* File: adq_pkg.sv */
// Purpose: Shared constants and types of the difference and quadrature calculator
// Assumes: 32-bit AXI4-Lite register access, 10 MHz system clock
// Notes:   Control word layout is fixed by the packed struct member order

package adq_pkg;

  localparam int unsigned CODE_W     = 12;
  localparam int unsigned CALC_W     = 13;
  localparam int unsigned CNT_W      = 10;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned CTRL_W     = 6;
  localparam int unsigned FRAME_BITS = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_DIFF   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_QUAD   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_CODES  = 8'h10;

  localparam logic [CTRL_W-1:0] CTRL_RST     = 6'h00;
  localparam logic [2:0]        QUAD_CHANNEL = 3'h6;
  localparam logic [4:0]        LAST_POS     = 5'h1F;
  localparam logic [2:0]        LEAD_ZEROS   = 3'h0;
  localparam logic [CALC_W-1:0] DIFF_OFFSET  = 13'h0001;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Bit 0 is the input type select, bits 3:1 the channel select
  typedef struct packed {
    logic       straight_binary;
    logic       calc_enable;
    logic [2:0] channel_select;
    logic       input_type_select;
  } adq_ctrl_t;

  typedef struct packed {
    logic             phase_a;
    logic             phase_b;
    logic             dir;
    logic [CNT_W-1:0] count;
  } adq_quad_t;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOAD   = 2'b01,
    ST_ACTIVE = 2'b10
  } adq_state_t;

endpackage

/* File: adq_quad_track.sv */
// Purpose: Quadrant, direction and step counter tracking of two phase-shifted inputs
// Assumes: step pulses once per sampled frame while the quadrature channel is selected
// Notes:   The first sample only primes the tracker; a two-quadrant jump holds direction and count
`timescale 1ns/1ps
`default_nettype none

module adq_quad_track
  import adq_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Sample strobe and phase bits
  input  wire logic       step,
  input  wire logic [1:0] phase_in,
  // Result
  output var  adq_quad_t  quad_out
);

  logic [1:0]       prev_reg;
  logic             primed_reg;
  logic             dir_reg;
  logic [CNT_W-1:0] count_reg;
  logic             fwd;
  logic             bwd;
  logic             a_toggle;

  // Reference rotation walks 00, 01, 11, 10
  assign fwd      = (phase_in == {prev_reg[0], ~prev_reg[1]});
  assign bwd      = (phase_in == {~prev_reg[0], prev_reg[1]});
  assign a_toggle = (phase_in[1] != prev_reg[1]);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prev_reg   <= 2'h0;
      primed_reg <= 1'b0;
    end else if (step) begin
      prev_reg   <= phase_in;
      primed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dir_reg <= 1'b0;
    end else if (step && primed_reg) begin
      if (fwd) begin
        dir_reg <= 1'b0;
      end else if (bwd) begin
        dir_reg <= 1'b1;
      end
    end
  end

  // Phase A changes twice per period, so counting its edges gives two steps
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_reg <= 10'h000;
    end else if (step && primed_reg && a_toggle) begin
      if (fwd) begin
        count_reg <= CNT_W'(count_reg + 10'h001);
      end else if (bwd) begin
        count_reg <= CNT_W'(count_reg - 10'h001);
      end
    end
  end

  assign quad_out = '{phase_a: prev_reg[1], phase_b: prev_reg[0], dir: dir_reg, count: count_reg};

  AST_CNT_UP: assert property (@(posedge clk) disable iff (sys_rst)
    step && primed_reg && fwd && a_toggle |=> count_reg == CNT_W'($past(count_reg) + 10'h001))
    else $error("step counter did not increment");

  AST_CNT_DOWN: assert property (@(posedge clk) disable iff (sys_rst)
    step && primed_reg && bwd && a_toggle |=> count_reg == CNT_W'($past(count_reg) - 10'h001))
    else $error("step counter did not decrement");

  AST_DIR_REVERSE: assert property (@(posedge clk) disable iff (sys_rst)
    step && primed_reg && bwd |=> dir_reg ##1 (dir_reg || $past(step)))
    else $error("direction bit not high after reverse step");

  AST_CNT_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !step |=> $stable(count_reg))
    else $error("step counter changed without a sample");

endmodule

`default_nettype wire

/* File: adq_host_model.sv */
// Purpose: Behavioural host that frames and clocks the serial readout
// Assumes: 800 ns serial clock, idle low, runs only inside frames
// Notes:   Samples each line just before the falling edge that moves it on
`timescale 1ns/1ps
`default_nettype none

module adq_host_model (
  // Link to the device
  output logic      frame_select_n,
  output logic      sclk,
  input  wire logic dout_a,
  input  wire logic dout_a_oe,
  input  wire logic dout_b,
  input  wire logic dout_b_oe
);
  logic line_a;
  logic line_b;

  // A released line reads as the inverse of its last bit, so a late enable cannot hide
  assign line_a = dout_a_oe ? dout_a : ~dout_a;
  assign line_b = dout_b_oe ? dout_b : ~dout_b;

  initial begin
    frame_select_n = 1'b1;
    sclk           = 1'b0;
  end

  // One frame of the given number of falling edges, full frame is 32
  task automatic frame(input int falls, output logic [31:0] wa, output logic [31:0] wb,
                       output logic oe_ok, output logic oe_mid, output logic oe_end);
    wa    = 32'h0;
    wb    = 32'h0;
    oe_ok = 1'b1;
    #737 frame_select_n = 1'b0;
    // Leave room for the device to load its words before the first edge
    #1000;
    for (int k = 0; k < falls; k++) begin
      sclk = 1'b1;
      #399;
      wa    = {wa[30:0], line_a};
      wb    = {wb[30:0], line_b};
      oe_ok = oe_ok & dout_a_oe & dout_b_oe;
      #1 sclk = 1'b0;
      #400;
    end
    #800;
    oe_mid = dout_a_oe | dout_b_oe;
    frame_select_n = 1'b1;
    #1000;
    oe_end = dout_a_oe | dout_b_oe;
  endtask
endmodule
`default_nettype wire

/* File: adq_calc_tb_top.sv */
// Purpose: Self-checking bench of the difference and quadrature calculator
// Assumes: Register answers come within a few cycles; frames use the host model
// Notes:   Expected words are rebuilt from codes, never read back from the design
`timescale 1ns/1ps
`default_nettype none

module adq_calc_tb_top
  import adq_pkg::*;
;
  logic              clk;
  logic              sys_rst;
  logic [ADDR_W-1:0] awaddr;
  logic [ADDR_W-1:0] araddr;
  logic              awvalid, wvalid, bready, arvalid, rready;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp;
  logic [1:0]        rresp;
  logic [CODE_W-1:0] code_a;
  logic [CODE_W-1:0] code_b;
  logic              sclk, fsel_n, dout_a, dout_a_oe, dout_b, dout_b_oe;
  int                n_errors;
  int                compares;

  adq_calc u_adq_calc (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_code_a(code_a),
    .conv_code_b(code_b), .sclk(sclk), .frame_select_n(fsel_n), .dout_a(dout_a),
    .dout_a_oe(dout_a_oe), .dout_b(dout_b), .dout_b_oe(dout_b_oe));

  adq_host_model u_adq_host_model (.frame_select_n(fsel_n), .sclk(sclk), .dout_a(dout_a),
    .dout_a_oe(dout_a_oe), .dout_b(dout_b), .dout_b_oe(dout_b_oe));

  always #50 clk = ~clk;

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      n_errors++;
    end
  endtask

  task automatic timeout(input string what);
    n_errors++;
    $display("FAIL %s expected handshake seen none", what);
    conclude();
  endtask

  // Ready is sampled between edges, so its value at the taking edge is the one used
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    int   n;
    aw_ok = 1'b0; w_ok = 1'b0; b_ok = 1'b0; n = 0; r = 2'h0;
    @(posedge clk);
    awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!b_ok && n < 50) begin
      @(negedge clk);
      aw_ok = awvalid && awready; w_ok = wvalid && wready; b_ok = bvalid && bready; r = bresp; n++;
      @(posedge clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok) bready <= 1'b0;
    end
    if (!b_ok) timeout("axi write");
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    int   n;
    ar_ok = 1'b0; r_ok = 1'b0; n = 0; d = 32'h0; r = 2'h0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!r_ok && n < 50) begin
      @(negedge clk);
      ar_ok = arvalid && arready; r_ok = rvalid && rready; d = rdata; r = rresp; n++;
      @(posedge clk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok) rready <= 1'b0;
    end
    if (!r_ok) timeout("axi read");
  endtask

  function automatic logic [31:0] fr(logic [11:0] x, logic [11:0] y);
    return {3'h0, x, 1'h0, 3'h0, y, 1'h0};
  endfunction
  function automatic logic [31:0] fw(logic [11:0] x, logic [12:0] w);
    return {3'h0, x, 1'h0, 2'h0, w, 1'h0};
  endfunction
  function automatic logic [12:0] df(logic [11:0] a, logic [11:0] b);
    return {1'b0, a} - {1'b0, b} - 13'h0001;
  endfunction
  function automatic logic [1:0] qph(int i);
    return (i == 0) ? 2'h0 : (i == 1) ? 2'h1 : (i == 2) ? 2'h3 : 2'h2;
  endfunction

  task automatic run_frame(input logic [11:0] a, input logic [11:0] b, input logic [31:0] eb,
                           input logic cb);
    logic [31:0] wa, wb;
    logic        ok, mid, fin;
    @(posedge clk);
    code_a <= a;
    code_b <= b;
    u_adq_host_model.frame(32, wa, wb, ok, mid, fin);
    chk("dout_a word", fr(a, b), wa);
    if (cb) chk("dout_b word", eb, wb);
    chk("oe in frame", 32'h1, {31'h0, ok});
    chk("oe after last fall", 32'h0, {31'h0, mid});
  endtask

  initial begin
    logic [31:0] d, v, wa, wb;
    logic [1:0]  r, ph, po;
    logic [11:0] a, b;
    logic        ok, mid, fin, q_dir;
    logic [9:0]  q_cnt;
    logic [23:0] corner [5];
    int          q_i, m, ni;
    clk = 1'b0; sys_rst = 1'b1; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    code_a = 12'h000; code_b = 12'h000; n_errors = 0; compares = 0;
    corner = '{24'hAAACCC, 24'h000FFF, 24'hFFF000, 24'h555555, 24'h000000};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    void'($urandom(58));
    axi_rd(OFF_CTRL, d, r);
    chk("ctrl reset", {26'h0, CTRL_RST}, d);
    @(negedge clk);
    chk("oe idle", 32'h0, {30'h0, dout_a_oe, dout_b_oe});
    v = $urandom;
    axi_wr(OFF_CTRL, v, r);
    chk("ctrl write resp", {30'h0, RESP_OKAY}, {30'h0, r});
    axi_rd(OFF_CTRL, d, r);
    chk("ctrl readback", {26'h0, v[5:0]}, d);
    axi_rd(OFF_STATUS, d, r);
    chk("status word", {29'h0, 1'b0, v[5], (!v[0] && v[3:1] == QUAD_CHANNEL)}, d);
    axi_wr(8'h40, 32'hFFFFFFFF, r);
    chk("unmapped write resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(8'h40, d, r);
    chk("unmapped read", {30'h0, RESP_SLVERR}, {d[29:0], r});
    axi_wr(OFF_CTRL, 32'h00000000, r);
    a = 12'($urandom);
    b = 12'($urandom);
    run_frame(a, b, fr(b, a), 1'b1);
    // Difference mode, not the quadrature channel
    axi_wr(OFF_CTRL, 32'h00000031, r);
    for (int i = 0; i < 11; i++) begin
      a = (i < 5) ? corner[i][23:12] : 12'($urandom);
      b = (i < 5) ? corner[i][11:0] : 12'($urandom);
      run_frame(a, b, fw(b, df(a, b)), 1'b1);
    end
    axi_rd(OFF_DIFF, d, r);
    chk("diff register", {19'h0, df(a, b)}, d);
    @(posedge clk);
    u_adq_host_model.frame(10, wa, wb, ok, mid, fin);
    v = fr(a, b);
    chk("aborted frame bits", {22'h0, v[31:22]}, {22'h0, wa[9:0]});
    chk("oe before select rise", 32'h1, {31'h0, mid});
    chk("oe after select rise", 32'h0, {31'h0, fin});
    // Quadrature channel: type 0, channel 110, calculated word on dout_b
    axi_wr(OFF_CTRL, 32'h0000001C, r);
    q_i = 0; q_cnt = 10'h000; q_dir = 1'b0;
    run_frame(12'h000, 12'h000, 32'h0, 1'b0);
    for (int s = 0; s < 24; s++) begin
      if (s == 12) begin
        // Tracker must ignore frames outside the quadrature channel
        axi_wr(OFF_CTRL, 32'h0000001D, r);
        a = 12'($urandom);
        b = 12'($urandom);
        run_frame(a, b, fw(b, df(a, b)), 1'b1);
        axi_wr(OFF_CTRL, 32'h0000001C, r);
      end
      m = (s == 0 || $urandom % 2 == 0) ? -1 : 1;
      ni = (q_i + m + 4) % 4;
      ph = qph(ni);
      po = qph(q_i);
      if (po[1] != ph[1]) q_cnt = q_cnt + ((m > 0) ? 10'h001 : 10'h3FF);
      q_dir = (m < 0);
      q_i = ni;
      a = {ph[1], 11'($urandom)};
      b = {ph[0], 11'($urandom)};
      run_frame(a, b, fw(b, {ph, q_dir, q_cnt}), 1'b1);
    end
    axi_rd(OFF_QUAD, d, r);
    chk("quad register", {19'h0, ph, q_dir, q_cnt}, d);
    conclude();
  end
endmodule
`default_nettype wire
